// ### src/cpu_opcode_operand_decode.sv
/*
  Instruction fetch and operand-addressing decode for a one-clock-per-cycle
  8-bit core. Assumes program memory returns pm_data in the same cycle as
  pm_addr and that the core supplies the two indirect pointer registers.
*/
// Overview of operation
// RULE1: first byte fetched is an 8-bit opcode that selects the action.
// RULE2: opcode alone tells whether one or two operand bytes follow.
// RULE3: one byte fetched per clock, decode overlapped with fetch.
// RULE4: direct address below 80h is RAM, 80h upward is a function register.
// RULE5: indirect address comes from pointer zero or one by opcode low bit.
// RULE6: immediates come from instruction bytes, 8 or 16 bits.
// RULE7: long call and jump carry a full 16-bit target.
// RULE8: absolute call and jump replace low 11 bits of next address.
// RULE9: relative offset is signed 8-bit added to next instruction address.
// RULE10: bit operand selects one bit in bit-addressable RAM or registers.
// RULE11: indirect access above 7fh reaches upper RAM, never registers.
`timescale 1ns/1ps
module cpu_opcode_operand_decode
  import opdec_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // program memory
  output logic [PC_W-1:0] pm_addr,
  input wire logic [7:0] pm_data,
  // core side
  input wire logic [2:0] reg_bank,
  input wire logic [7:0] ptr0,
  input wire logic [7:0] ptr1,
  // decode results
  output logic instr_valid,
  output logic [7:0] opcode_out,
  output operand_kind_t kind_out,
  output logic [1:0] length_out,
  output logic [7:0] data_addr,
  output data_target_t data_target,
  output logic [2:0] bit_index,
  output logic [15:0] imm_value,
  output logic [PC_W-1:0] branch_target,
  output logic [PC_W-1:0] next_pc
);
  typedef enum logic [1:0] {st_opcode, st_byte2, st_byte3} fetch_state_t;

  typedef struct packed {
    fetch_state_t st;
    logic [PC_W-1:0] pc;
    logic [7:0] op;
    logic [1:0] len;
    operand_kind_t kind;
    logic [7:0] b2;
    logic valid;
    logic [7:0] opc_o;
    operand_kind_t kind_o;
    logic [1:0] len_o;
    logic [7:0] daddr_o;
    data_target_t tgt_o;
    logic [2:0] bit_o;
    logic [15:0] imm_o;
    logic [PC_W-1:0] br_o;
    logic [PC_W-1:0] npc_o;
  } state_t;

  state_t state_r;
  state_t state_nxt;
  logic [1:0] lut_len;
  operand_kind_t lut_kind;

  // ------------------------------------------------------------
  // length lookup
  // ------------------------------------------------------------
  opcode_length u_len (
    .opcode(pm_data),
    .length(lut_len),
    .kind(lut_kind)
  );

  // direct address region split
  function automatic data_target_t direct_region(input logic [7:0] a);
    return (a < SFR_BASE) ? tgt_ram : tgt_sfr; // RULE4
  endfunction

  // bit address to byte address
  function automatic logic [7:0] bit_byte(input logic [7:0] b);
    return b[7] ? {b[7:3], 3'h0} : BIT_RAM_BASE + {4'h0, b[6:3]}; // RULE10
  endfunction

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic [PC_W-1:0] pc_inc;
    logic [7:0] op;
    logic [7:0] ind;
    logic finish;
    logic [7:0] first_opnd;
    state_nxt = state_r;
    pc_inc = state_r.pc + PC_ONE; // RULE3
    op = (state_r.st == st_opcode) ? pm_data : state_r.op;
    ind = op[0] ? ptr1 : ptr0; // RULE5
    // a two-byte form ends before b2 is registered, so take it off the bus
    first_opnd = (state_r.st == st_byte2) ? pm_data : state_r.b2;
    finish = 1'b0;
    state_nxt.valid = 1'b0;
    state_nxt.pc = pc_inc;
    case (state_r.st)
      st_opcode: begin
        state_nxt.op = pm_data; // RULE1
        state_nxt.len = lut_len;
        state_nxt.kind = lut_kind;
        if (lut_len == 2'd1) begin // RULE2
          finish = 1'b1;
        end else begin
          state_nxt.st = st_byte2;
        end
      end
      st_byte2: begin
        state_nxt.b2 = pm_data;
        if (state_r.len == 2'd3) begin
          state_nxt.st = st_byte3;
        end else begin
          finish = 1'b1;
        end
      end
      st_byte3: begin
        finish = 1'b1;
      end
      default: begin
        state_nxt.st = st_opcode;
      end
    endcase
    if (finish) begin
      state_nxt.st = st_opcode;
      state_nxt.valid = 1'b1;
      state_nxt.opc_o = op;
      state_nxt.kind_o = (state_r.st == st_opcode) ? lut_kind : state_r.kind;
      state_nxt.len_o = (state_r.st == st_opcode) ? lut_len : state_r.len;
      state_nxt.npc_o = pc_inc;
      state_nxt.daddr_o = 8'h00;
      state_nxt.tgt_o = tgt_ram;
      state_nxt.bit_o = 3'h0;
      state_nxt.imm_o = 16'h0000;
      state_nxt.br_o = pc_inc;
      case (state_nxt.kind_o)
        opk_reg: begin
          state_nxt.daddr_o = {3'h0, reg_bank[1:0], op[2:0]};
        end
        opk_indirect: begin
          state_nxt.daddr_o = ind;
          state_nxt.tgt_o = (ind < SFR_BASE) ? tgt_ram : tgt_upper_ram; // RULE11
        end
        opk_direct: begin
          state_nxt.daddr_o = first_opnd;
          state_nxt.tgt_o = direct_region(first_opnd); // RULE4
          state_nxt.imm_o = {8'h00, pm_data};
        end
        opk_imm8: begin
          // imm8 forms: second byte is the constant; three-byte compare-and-branch also takes last byte as offset
          state_nxt.imm_o = {8'h00, first_opnd}; // RULE6
          state_nxt.br_o = pc_inc + {{8{pm_data[7]}}, pm_data};
        end
        opk_imm16: begin
          state_nxt.imm_o = {state_r.b2, pm_data}; // RULE6
        end
        opk_full_branch_target: begin
          state_nxt.br_o = {state_r.b2, pm_data}; // RULE7
        end
        opk_in_page_branch_target: begin
          state_nxt.br_o = {pc_inc[PC_W-1:PAGE_BITS], op[7:5], pm_data}; // RULE8
        end
        opk_rel: begin
          state_nxt.br_o = pc_inc + {{8{pm_data[7]}}, pm_data}; // RULE9
        end
        opk_bit: begin
          state_nxt.daddr_o = bit_byte(first_opnd);
          state_nxt.tgt_o = first_opnd[7] ? tgt_sfr : tgt_ram; // RULE10
          state_nxt.bit_o = first_opnd[2:0];
          state_nxt.br_o = pc_inc + {{8{pm_data[7]}}, pm_data};
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r <= '{st: st_opcode, pc: PC_RESET, kind: opk_none, kind_o: opk_none,
                   tgt_o: tgt_ram, default: '0};
    end else if (clk_en) begin
      state_r <= state_nxt;
    end
  end

  assign pm_addr = state_r.pc;
  assign instr_valid = state_r.valid;
  assign opcode_out = state_r.opc_o;
  assign kind_out = state_r.kind_o;
  assign length_out = state_r.len_o;
  assign data_addr = state_r.daddr_o;
  assign data_target = state_r.tgt_o;
  assign bit_index = state_r.bit_o;
  assign imm_value = state_r.imm_o;
  assign branch_target = state_r.br_o;
  assign next_pc = state_r.npc_o;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  AST_PC_STEP: assert property (@(posedge clk) disable iff (reset) // RULE3
    clk_en |=> pm_addr == $past(pm_addr) + PC_ONE) else $error("pc did not advance");
  AST_LEN_SPACING: assert property (@(posedge clk) disable iff (reset) // RULE2
    instr_valid && (kind_out == opk_reg || kind_out == opk_indirect) |-> length_out == 2'd1)
    else $error("bad length");
  AST_DIRECT_SPLIT: assert property (@(posedge clk) disable iff (reset) // RULE4
    instr_valid && kind_out == opk_direct |-> (data_target == tgt_sfr) == data_addr[7])
    else $error("direct region wrong");
  AST_INDIRECT_NO_SFR: assert property (@(posedge clk) disable iff (reset) // RULE11
    instr_valid && kind_out == opk_indirect |-> data_target != tgt_sfr)
    else $error("indirect reached register");
  AST_INDIRECT_UPPER: assert property (@(posedge clk) disable iff (reset) // RULE11
    instr_valid && kind_out == opk_indirect |-> (data_target == tgt_upper_ram) == data_addr[7])
    else $error("indirect target wrong");
  AST_PAGE_KEEP: assert property (@(posedge clk) disable iff (reset) // RULE8
    instr_valid && kind_out == opk_in_page_branch_target |->
    branch_target[PC_W-1:PAGE_BITS] == next_pc[PC_W-1:PAGE_BITS])
    else $error("absolute branch left page");
  AST_LEN_MATCH: assert property (@(posedge clk) disable iff (reset) // RULE1
    instr_valid && kind_out == opk_none |-> length_out == 2'd1)
    else $error("no-operand opcode not one byte");
  AST_FULL_LEN: assert property (@(posedge clk) disable iff (reset) // RULE7
    instr_valid && kind_out == opk_full_branch_target |-> length_out == 2'd3)
    else $error("long branch not three bytes");
  AST_REL_RANGE: assert property (@(posedge clk) disable iff (reset) // RULE9
    instr_valid && kind_out == opk_rel |->
    (branch_target - next_pc) < 16'h0080 || (branch_target - next_pc) >= 16'hff80)
    else $error("relative target out of range");
  AST_IMM16_LEN: assert property (@(posedge clk) disable iff (reset) // RULE6
    instr_valid && kind_out == opk_imm16 |-> length_out == 2'd3)
    else $error("long immediate length wrong");
  AST_BIT_SFR: assert property (@(posedge clk) disable iff (reset) // RULE10
    instr_valid && kind_out == opk_bit && data_target == tgt_sfr |->
    (data_addr & BIT_SFR_MASK) == 8'h00) else $error("bit register not aligned");

  COV_LONG: cover property (@(posedge clk) instr_valid && kind_out == opk_full_branch_target);
  COV_ABS: cover property (@(posedge clk) instr_valid && kind_out == opk_in_page_branch_target);
  COV_IND_UP: cover property (@(posedge clk) instr_valid && data_target == tgt_upper_ram);
  COV_BIT: cover property (@(posedge clk) instr_valid && kind_out == opk_bit);
endmodule

// ### src/opcode_length.sv
/*
  Combinational length and operand-kind lookup for one opcode byte.
  Assumes the caller samples the answer in the cycle the opcode is valid.
*/
`timescale 1ns/1ps
module opcode_length
  import opdec_pkg::*;
(
  // opcode in
  input wire logic [7:0] opcode,
  // decode out
  output logic [1:0] length,
  output operand_kind_t kind
);
  always_comb begin
    length = 2'd1;
    kind = opk_none;
    if (opcode[4:0] == 5'h01 || opcode[4:0] == 5'h11) begin
      length = 2'd2;
      kind = opk_in_page_branch_target;
    end else if (opcode == 8'h02 || opcode == 8'h12) begin
      length = 2'd3;
      kind = opk_full_branch_target;
    end else if (opcode == 8'h90) begin
      length = 2'd3;
      kind = opk_imm16;
    end else if (opcode == 8'h80 || opcode == 8'h40 || opcode == 8'h50 ||
                 opcode == 8'h60 || opcode == 8'h70) begin
      length = 2'd2;
      kind = opk_rel;
    end else if (opcode == 8'h10 || opcode == 8'h20 || opcode == 8'h30) begin
      length = 2'd3;
      kind = opk_bit;
    end else if (opcode[7:4] == 4'hb && opcode[3:2] != 2'b00) begin
      length = 2'd3;
      kind = opk_imm8;
    end else if (opcode[7:4] == 4'hd && opcode[3]) begin
      length = 2'd2;
      kind = opk_rel;
    end else if (opcode == 8'h72 || opcode == 8'h82 || opcode == 8'h92 ||
                 opcode == 8'ha0 || opcode == 8'ha2 || opcode == 8'hb0 ||
                 opcode == 8'hb2 || opcode == 8'hc2 || opcode == 8'hd2) begin
      length = 2'd2;
      kind = opk_bit;
    end else if (opcode == 8'h43 || opcode == 8'h53 || opcode == 8'h63 ||
                 opcode == 8'h75 || opcode == 8'h85 || opcode == 8'hd5) begin
      length = 2'd3;
      kind = opk_direct;
    end else if (opcode[3:0] == 4'h4 && (opcode[7:4] inside {4'h2, 4'h3, 4'h4, 4'h5,
                 4'h6, 4'h7, 4'h9})) begin
      length = 2'd2;
      kind = opk_imm8;
    end else if (opcode[7:4] == 4'h7 && (opcode[3] || opcode[3:1] == 3'b011)) begin
      // pointer-looking 76h/77h still carry a constant byte
      length = 2'd2;
      kind = opk_imm8;
    end else if (opcode[3:0] == 4'h5 || opcode == 8'h42 || opcode == 8'h52 ||
                 opcode == 8'h62 || opcode == 8'hc0 || opcode == 8'hd0 ||
                 opcode[7:4] == 4'h8 && (opcode[3] || opcode[3:1] == 3'b011) ||
                 opcode[7:4] == 4'ha && (opcode[3] || opcode[3:1] == 3'b011)) begin
      length = 2'd2;
      kind = opk_direct;
    end else if (opcode[3:1] == 3'b011) begin
      kind = opk_indirect;
    end else if (opcode[3]) begin
      kind = opk_reg;
    end
  end
endmodule

// ### src/opdec_pkg.sv
/*
  Shared constants and types for the opcode fetch and operand decode block.
  Assumes a byte-wide program memory that answers a fetch in the same cycle.
*/
package opdec_pkg;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned PC_W = 16;
  localparam int unsigned PAGE_BITS = 11;
  localparam logic [7:0] SFR_BASE = 8'h80;
  localparam logic [7:0] BIT_RAM_BASE = 8'h20;
  localparam logic [7:0] BIT_SFR_MASK = 8'h07;
  localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
  localparam logic [PC_W-1:0] PC_ONE = 16'h0001;

  typedef enum logic [3:0] {
    opk_none, opk_reg, opk_direct, opk_indirect, opk_imm8, opk_imm16,
    opk_full_branch_target, opk_in_page_branch_target, opk_rel, opk_bit
  } operand_kind_t;

  typedef enum logic [1:0] {
    tgt_ram, tgt_upper_ram, tgt_sfr
  } data_target_t;
endpackage

// ### verification/cpu_opcode_operand_decode_test.sv
/*
  Self-checking bench for the opcode fetch and operand decode block.
  Assumes prog_mem as the program memory and the core side held steady.
*/
`timescale 1ns/1ps
`define CMP(got, exp) begin checked++; if ((got) !== (exp)) begin error_cnt++; \
  $display("FAIL %0t got %0h expected %0h", $time, got, exp); end end
module cpu_opcode_operand_decode_test import opdec_pkg::*;;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic [2:0] reg_bank = 3'h0;
  logic [7:0] ptr0 = 8'h00;
  logic [7:0] ptr1 = 8'h00;
  logic [15:0] pm_addr, imm_value, branch_target, next_pc;
  logic [7:0] pm_data, opcode_out, data_addr;
  logic instr_valid;
  operand_kind_t kind_out;
  logic [1:0] length_out;
  data_target_t data_target;
  logic [2:0] bit_index;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;

  always #4 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  cpu_opcode_operand_decode cpu_opcode_operand_decode_i (.clk(clk), .reset(reset),
    .clk_en(clk_en), .pm_addr(pm_addr), .pm_data(pm_data), .reg_bank(reg_bank),
    .ptr0(ptr0), .ptr1(ptr1), .instr_valid(instr_valid), .opcode_out(opcode_out),
    .kind_out(kind_out), .length_out(length_out), .data_addr(data_addr),
    .data_target(data_target), .bit_index(bit_index), .imm_value(imm_value),
    .branch_target(branch_target), .next_pc(next_pc));
  prog_mem prog_mem_i (.addr(pm_addr), .data(pm_data));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic results();
    if (error_cnt == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // memory is loaded under reset so the first fetch sees it
  task automatic prep(int a, logic [7:0] q[], int n);
    @(posedge clk) reset <= 1'b1;
    for (int i = 0; i < 4096; i++) prog_mem_i.mem[i] = 8'h00;
    foreach (q[i]) prog_mem_i.mem[a + i] = q[i];
    repeat (n) @(posedge clk);
    reset <= 1'b0;
  endtask

  // filler bytes are one-byte no-ops, skipped here
  task automatic chk(logic [7:0] op, operand_kind_t k, logic [1:0] len, logic [15:0] np);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (!(instr_valid === 1'b1 && opcode_out !== 8'h00) && n < 3000);
    `CMP(n < 3000, 1'b1)
    `CMP(opcode_out, op)
    `CMP(kind_out, k)
    `CMP(length_out, len)
    `CMP(next_pc, np)
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_long();
    logic [15:0] hold;
    int c0;
    prep(0, '{8'h02, 8'h12, 8'h34, 8'h12, 8'hab, 8'hcd}, 20);
    @(posedge clk) clk_en <= 1'b0;
    #1 hold = pm_addr;
    repeat (3) @(posedge clk);
    #1 `CMP(pm_addr, hold)
    @(posedge clk) clk_en <= 1'b1;
    chk(8'h02, opk_full_branch_target, 2'd3, 16'h0003);
    `CMP(branch_target, 16'h1234)
    c0 = cyc;
    chk(8'h12, opk_full_branch_target, 2'd3, 16'h0006);
    `CMP(branch_target, 16'habcd)
    `CMP(cyc - c0, 3)
  endtask

  // jump sits on the last bytes of page 0, so its next address is page 1
  task automatic t_page();
    prep(16'h07fe, '{8'he1, 8'h55, 8'h31, 8'h02}, 2);
    chk(8'he1, opk_in_page_branch_target, 2'd2, 16'h0800);
    `CMP(branch_target, 16'h0f55)
    chk(8'h31, opk_in_page_branch_target, 2'd2, 16'h0802);
    `CMP(branch_target, 16'h0902)
  endtask

  task automatic t_rel();
    prep(0, '{8'h80, 8'h80, 8'h80, 8'h7f}, 2);
    chk(8'h80, opk_rel, 2'd2, 16'h0002);
    `CMP(branch_target, 16'hff82)
    chk(8'h80, opk_rel, 2'd2, 16'h0004);
    `CMP(branch_target, 16'h0083)
  endtask

  task automatic t_data();
    @(posedge clk);
    ptr0 <= 8'h12;
    ptr1 <= 8'hc5;
    reg_bank <= 3'h6;
    prep(0, '{8'he5, 8'h30, 8'he5, 8'h90, 8'he7, 8'he6, 8'hea, 8'h74, 8'h5a,
      8'h90, 8'hbe, 8'hef}, 2);
    chk(8'he5, opk_direct, 2'd2, 16'h0002);
    `CMP({data_addr, data_target}, {8'h30, tgt_ram})
    chk(8'he5, opk_direct, 2'd2, 16'h0004);
    `CMP({data_addr, data_target}, {8'h90, tgt_sfr})
    chk(8'he7, opk_indirect, 2'd1, 16'h0005);
    `CMP({data_addr, data_target}, {8'hc5, tgt_upper_ram})
    chk(8'he6, opk_indirect, 2'd1, 16'h0006);
    `CMP({data_addr, data_target}, {8'h12, tgt_ram})
    chk(8'hea, opk_reg, 2'd1, 16'h0007);
    `CMP(data_addr, 8'h12)
    chk(8'h74, opk_imm8, 2'd2, 16'h0009);
    `CMP(imm_value[7:0], 8'h5a)
    chk(8'h90, opk_imm16, 2'd3, 16'h000c);
    `CMP(imm_value, 16'hbeef)
  endtask

  task automatic t_bit();
    prep(0, '{8'hd2, 8'h2f, 8'hd2, 8'h8b, 8'hc2, 8'h00}, 2);
    chk(8'hd2, opk_bit, 2'd2, 16'h0002);
    `CMP({data_addr, bit_index, data_target}, {8'h25, 3'h7, tgt_ram})
    chk(8'hd2, opk_bit, 2'd2, 16'h0004);
    `CMP({data_addr, bit_index, data_target}, {8'h88, 3'h3, tgt_sfr})
    chk(8'hc2, opk_bit, 2'd2, 16'h0006);
    `CMP({data_addr, bit_index, data_target}, {8'h20, 3'h0, tgt_ram})
  endtask

  // three-byte forms, and opcodes whose low bits look like another form
  task automatic t_three();
    prep(0, '{8'h75, 8'ha0, 8'h3c, 8'hb4, 8'h5a, 8'hfe, 8'h20, 8'h2f, 8'h10,
      8'h76, 8'h44, 8'h84, 8'ha4, 8'h86, 8'h40}, 2);
    chk(8'h75, opk_direct, 2'd3, 16'h0003);
    `CMP({data_addr, data_target, imm_value}, {8'ha0, tgt_sfr, 16'h003c})
    chk(8'hb4, opk_imm8, 2'd3, 16'h0006);
    `CMP({imm_value, branch_target}, {16'h005a, 16'h0004})
    chk(8'h20, opk_bit, 2'd3, 16'h0009);
    `CMP({data_addr, bit_index, branch_target}, {8'h25, 3'h7, 16'h0019})
    chk(8'h76, opk_imm8, 2'd2, 16'h000b);
    `CMP(imm_value, 16'h0044)
    chk(8'h84, opk_none, 2'd1, 16'h000c);
    chk(8'ha4, opk_none, 2'd1, 16'h000d);
    chk(8'h86, opk_direct, 2'd2, 16'h000f);
    `CMP({data_addr, data_target}, {8'h40, tgt_ram})
  endtask

  initial begin
    t_long();
    t_page();
    t_rel();
    t_data();
    t_bit();
    t_three();
    results();
  end

  // whole run needs about 2,140 cycles
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    results();
  end
endmodule

// ### verification/prog_mem.sv
/*
  Program memory model standing at the fetch port of the decode block.
  Assumes the bench preloads mem by hierarchical write while reset is held.
*/
`timescale 1ns/1ps
module prog_mem (
  // fetch port
  input wire logic [15:0] addr,
  output logic [7:0] data
);
  // ----------------------------------------
  // storage
  // ----------------------------------------
  // only 4K deep: higher addresses alias, enough for two pages
  logic [7:0] mem [0:4095];
  // same-cycle answer, one byte per fetch
  assign data = mem[addr[11:0]];
endmodule
